// ---- rtl/frrc_fault_ctrl.sv ----
// Purpose: under-temperature and input overvoltage fault reaction with retry
// Assumes: fault and hysteresis comparisons arrive as synchronous levels
// Notes: command port is the decoded side of the management bus engine
`timescale 1ns/1ps

module frrc_fault_ctrl #(
  parameter int TICK_CYCLES = frrc_pkg::TICK_CYCLES
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // decoded commands
  input wire frrc_pkg::frrc_cmd_t i_cmd,
  input wire logic i_clear_faults,
  output logic [15:0] o_rd_data,
  output logic o_rd_valid,
  output logic o_wr_rejected,
  // straps
  input wire logic [7:0] i_config_strap_pin_zero,
  // fault comparisons
  input wire logic i_cold_fault,
  input wire logic i_temp_above_cold_warning,
  input wire logic i_vin_ov_fault,
  input wire logic i_vin_below_ov_caution,
  // enable and retry stop sources
  input wire logic i_enable,
  input wire logic i_bias_lost,
  input wire logic i_other_fault,
  // output control and status
  output logic o_output_enable,
  output logic o_restart_attempt,
  output logic o_alert_line_n,
  output logic o_cold_fault_status,
  output logic o_vin_ov_fault_status
);

  // ********************************************************************
  // registers
  // ********************************************************************
  frrc_pkg::frrc_react_t cold_react_q;
  frrc_pkg::frrc_react_t ov_react_q;
  logic [15:0] ov_trip_q;
  logic strap_loaded_q;
  frrc_pkg::frrc_state_t state_q;
  frrc_pkg::frrc_state_t state_d;
  logic cause_ov_q;
  logic cause_ov_d;
  logic cold_stat_q;
  logic ov_stat_q;

  // ********************************************************************
  // command decode
  // ********************************************************************
  wire wr_cold_react = i_cmd.wr && (i_cmd.code == frrc_pkg::CMD_COLD_REACT);
  wire wr_ov_trip = i_cmd.wr && (i_cmd.code == frrc_pkg::CMD_VIN_OV_TRIP);
  wire wr_ov_react = i_cmd.wr && (i_cmd.code == frrc_pkg::CMD_VIN_OV_REACT);

  // linear-11 range check of a new trip level
  wire signed [4:0] l11_exp = i_cmd.data[frrc_pkg::L11_EXP_MSB:frrc_pkg::L11_EXP_LSB];
  wire signed [10:0] l11_mant = i_cmd.data[frrc_pkg::L11_MANT_MSB:frrc_pkg::L11_MANT_LSB];
  wire [4:0] l11_shift = l11_exp[4] ? 5'(-l11_exp) : 5'(l11_exp);
  wire [31:0] mant_abs = {22'h0, l11_mant[9:0]};
  wire [31:0] max_v = 32'(frrc_pkg::VIN_OV_MAX_V);
  wire [31:0] scaled_mant = mant_abs << l11_shift;
  wire [31:0] scaled_max = max_v << l11_shift;
  wire in_range = !l11_mant[10] &&
                  (l11_exp[4] ? (mant_abs <= scaled_max) : (scaled_mant <= max_v));
  wire trip_reject = wr_ov_trip && !in_range;

  // read data selection
  wire [15:0] rd_sel =
    (i_cmd.code == frrc_pkg::CMD_COLD_REACT) ? {8'h00, cold_react_q} :
    (i_cmd.code == frrc_pkg::CMD_VIN_OV_TRIP) ? ov_trip_q :
    (i_cmd.code == frrc_pkg::CMD_VIN_OV_REACT) ? {8'h00, ov_react_q} : 16'h0000;

  // ********************************************************************
  // configuration registers
  // ********************************************************************
  // strap caught on the first clock after reset release
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      strap_loaded_q <= 1'b0;
    end else begin
      strap_loaded_q <= 1'b1;
    end
  end

  // cold reaction config
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cold_react_q <= frrc_pkg::REACT_RST;
    end else if (!strap_loaded_q) begin
      cold_react_q <= i_config_strap_pin_zero;
    end else if (wr_cold_react) begin
      cold_react_q <= i_cmd.data[7:0];
    end
  end

  // overvoltage reaction config
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ov_react_q <= frrc_pkg::REACT_RST;
    end else if (!strap_loaded_q) begin
      ov_react_q <= i_config_strap_pin_zero;
    end else if (wr_ov_react) begin
      ov_react_q <= i_cmd.data[7:0];
    end
  end

  // overvoltage trip level, kept on a refused write
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ov_trip_q <= frrc_pkg::VIN_OV_TRIP_RST;
    end else if (wr_ov_trip && in_range) begin
      ov_trip_q <= i_cmd.data;
    end
  end

  // read answer, data held until the next read
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rd_data <= 16'h0000;
      o_rd_valid <= 1'b0;
    end else begin
      o_rd_data <= i_cmd.rd ? rd_sel : o_rd_data;
      o_rd_valid <= i_cmd.rd;
    end
  end

  // one-cycle refusal flag for an out-of-range trip level
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_wr_rejected <= 1'b0;
    end else begin
      o_wr_rejected <= trip_reject;
    end
  end

  // ********************************************************************
  // fault detection and status
  // ********************************************************************
  wire running = (state_q == frrc_pkg::FRRC_RUN) && i_enable;
  wire cold_acts = cold_react_q.resp == frrc_pkg::RESP_DISABLE_RETRY;
  wire ov_acts = ov_react_q.resp == frrc_pkg::RESP_DISABLE_RETRY;
  wire cold_trip = running && i_cold_fault && cold_acts;
  wire ov_trip = running && i_vin_ov_fault && ov_acts && !cold_trip;
  wire any_trip = cold_trip || ov_trip;

  // sticky cold status, set wins over clear
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cold_stat_q <= 1'b0;
    end else begin
      cold_stat_q <= i_cold_fault || (cold_stat_q && !i_clear_faults);
    end
  end

  // sticky overvoltage status, set wins over clear
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ov_stat_q <= 1'b0;
    end else begin
      ov_stat_q <= i_vin_ov_fault || (ov_stat_q && !i_clear_faults);
    end
  end

  // ********************************************************************
  // retry sequencer
  // ********************************************************************
  frrc_pkg::frrc_react_t act_cfg;
  wire [2:0] new_delay = cold_trip ? cold_react_q.delay : ov_react_q.delay;
  wire [frrc_pkg::MS_CNT_W-1:0] new_delay_ms =
    frrc_pkg::MS_CNT_W'(({6'h00, new_delay} + 9'h001) * 9'(frrc_pkg::RETRY_UNIT_MS));
  wire [frrc_pkg::MS_CNT_W-1:0] act_delay_ms =
    frrc_pkg::MS_CNT_W'(({6'h00, act_cfg.delay} + 9'h001) * 9'(frrc_pkg::RETRY_UNIT_MS));
  wire [2:0] new_retry = cold_trip ? cold_react_q.retry : ov_react_q.retry;
  wire hyst_ok = cause_ov_q ? i_vin_below_ov_caution : i_temp_above_cold_warning;
  wire other_cause = cause_ov_q ? i_cold_fault : i_vin_ov_fault;
  wire stop_hard = i_bias_lost || i_other_fault || other_cause;
  wire timer_expired;
  wire restart = (state_q == frrc_pkg::FRRC_WAIT_HYST) && !stop_hard && i_enable && hyst_ok;
  wire timer_load = (any_trip && (new_retry != frrc_pkg::RETRY_NONE)) || restart;

  assign act_cfg = cause_ov_q ? ov_react_q : cold_react_q;

  frrc_ms_timer #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_timer (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_load(timer_load),
    .i_load_ms(any_trip ? new_delay_ms : act_delay_ms),
    .o_expired(timer_expired)
  );

  // next state
  always_comb begin
    state_d = state_q;
    cause_ov_d = cause_ov_q;
    unique case (state_q)
      frrc_pkg::FRRC_RUN: begin
        if (any_trip) begin
          cause_ov_d = ov_trip;
          if (new_retry == frrc_pkg::RETRY_NONE) begin
            state_d = frrc_pkg::FRRC_LATCHED;
          end else begin
            state_d = frrc_pkg::FRRC_WAIT_DELAY;
          end
        end
      end
      frrc_pkg::FRRC_WAIT_DELAY: begin
        if (stop_hard) begin
          state_d = frrc_pkg::FRRC_LATCHED;
        end else if (!i_enable) begin
          state_d = frrc_pkg::FRRC_RUN;
        end else if (timer_expired) begin
          state_d = frrc_pkg::FRRC_WAIT_HYST;
        end
      end
      frrc_pkg::FRRC_WAIT_HYST: begin
        if (stop_hard) begin
          state_d = frrc_pkg::FRRC_LATCHED;
        end else if (!i_enable || hyst_ok) begin
          state_d = frrc_pkg::FRRC_RUN;
        end
      end
      frrc_pkg::FRRC_LATCHED: begin
        state_d = frrc_pkg::FRRC_LATCHED;
      end
    endcase
  end

  // sequencer state
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= frrc_pkg::FRRC_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // fault cause, picks the hysteresis and delay source
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cause_ov_q <= 1'b0;
    end else begin
      cause_ov_q <= cause_ov_d;
    end
  end

  // ********************************************************************
  // outputs
  // ********************************************************************
  // next values of the pins
  wire oe_d = (state_d == frrc_pkg::FRRC_RUN) && i_enable && strap_loaded_q;
  wire alert_n_d = !(cold_stat_q || ov_stat_q);

  // output enable, off until the strap has loaded the configs
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_output_enable <= 1'b0;
    end else begin
      o_output_enable <= oe_d;
    end
  end

  // one pulse per restart attempt
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_restart_attempt <= 1'b0;
    end else begin
      o_restart_attempt <= restart;
    end
  end

  // alert level follows the sticky status
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_alert_line_n <= 1'b1;
    end else begin
      o_alert_line_n <= alert_n_d;
    end
  end

  // status pins
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_cold_fault_status <= 1'b0;
      o_vin_ov_fault_status <= 1'b0;
    end else begin
      o_cold_fault_status <= cold_stat_q;
      o_vin_ov_fault_status <= ov_stat_q;
    end
  end

endmodule : frrc_fault_ctrl

// ---- rtl/frrc_pkg.sv ----
// Purpose: shared constants and types for the fault reaction and retry block
// Assumes: 10 MHz system clock, command codes already decoded by the bus engine
// Notes: register values travel as packed structs declared here

package frrc_pkg;

  // ********************************************************************
  // command codes
  // ********************************************************************
  localparam logic [7:0] CMD_COLD_REACT = 8'h54;
  localparam logic [7:0] CMD_VIN_OV_TRIP = 8'h55;
  localparam logic [7:0] CMD_VIN_OV_REACT = 8'h56;

  // ********************************************************************
  // reset values and field codes
  // ********************************************************************
  localparam logic [15:0] VIN_OV_TRIP_RST = 16'hda00;
  localparam logic [7:0] REACT_RST = 8'h00;
  localparam logic [1:0] RESP_DISABLE_RETRY = 2'h2;
  localparam logic [2:0] RETRY_NONE = 3'h0;

  // linear-11 word layout
  localparam int L11_EXP_MSB = 15;
  localparam int L11_EXP_LSB = 11;
  localparam int L11_MANT_MSB = 10;
  localparam int L11_MANT_LSB = 0;
  localparam int VIN_OV_MAX_V = 18;

  // ********************************************************************
  // timing
  // ********************************************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int RETRY_UNIT_MS = 35;
  localparam int RETRY_MAX_MS = 280;
  localparam int MS_CNT_W = $clog2(RETRY_MAX_MS + 1);

  // reaction register fields, msb first: response 7:6, retry 5:3, delay 2:0
  typedef struct packed {
    logic [1:0] resp;
    logic [2:0] retry;
    logic [2:0] delay;
  } frrc_react_t;

  // one command from the bus engine
  typedef struct packed {
    logic [7:0] code;
    logic [15:0] data;
    logic wr;
    logic rd;
  } frrc_cmd_t;

  // fault sequencer states, gray along run -> delay -> hyst
  typedef enum logic [1:0] {
    FRRC_RUN = 2'h0,
    FRRC_WAIT_DELAY = 2'h1,
    FRRC_WAIT_HYST = 2'h3,
    FRRC_LATCHED = 2'h2
  } frrc_state_t;

endpackage : frrc_pkg

// ---- rtl/frrc_ms_timer.sv ----
// Purpose: millisecond tick and retry delay down counter
// Assumes: load is a one-cycle pulse from the fault sequencer
// Notes: load restarts the tick prescaler so the first millisecond is whole
`timescale 1ns/1ps

module frrc_ms_timer #(
  parameter int TICK_CYCLES = frrc_pkg::TICK_CYCLES
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // load request
  input wire logic i_load,
  input wire logic [frrc_pkg::MS_CNT_W-1:0] i_load_ms,
  // status
  output logic o_expired
);

  localparam int PRE_W = $clog2(TICK_CYCLES);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYCLES - 1);

  logic [PRE_W-1:0] pre_q;
  logic [frrc_pkg::MS_CNT_W-1:0] ms_q;
  wire tick = (pre_q == PRE_LAST);
  wire ms_zero = (ms_q == '0);

  // prescaler from system clock to 1 ms
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pre_q <= '0;
    end else if (i_load || tick) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + 1'b1;
    end
  end

  // delay counter, reloaded on fault and on each restart
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ms_q <= '0;
    end else if (i_load) begin
      ms_q <= i_load_ms;
    end else if (tick && !ms_zero) begin
      ms_q <= ms_q - 1'b1;
    end
  end

  assign o_expired = ms_zero && !i_load;

endmodule : frrc_ms_timer

// ---- sim/frrc_host_model.sv ----
// Purpose: management host issuing decoded configuration commands
// Assumes: one-cycle commands, answer one cycle after a read
// Notes: signals change 1 ns after a rising edge
`timescale 1ns/1ps

module frrc_host_model (
  // clock
  input wire logic i_clk,
  // answers from the block
  input wire logic [15:0] i_rd_data,
  input wire logic i_rd_valid,
  // commands to the block
  output frrc_pkg::frrc_cmd_t o_cmd,
  output logic o_clear_faults
);
  // ********
  // command tasks
  // ********
  initial begin
    o_cmd = '0;
    o_clear_faults = 1'b0;
  end

  // one command held for exactly one taking edge
  task automatic send(input logic [7:0] code, input logic [15:0] data, input logic rd);
    @(posedge i_clk);
    #1;
    o_cmd = '{code: code, data: data, wr: !rd, rd: rd};
    @(posedge i_clk);
    #1;
    o_cmd = '0;
  endtask : send

  // read, then wait a bounded time for the answer
  task automatic read(input logic [7:0] code, output logic [15:0] d, output logic ok);
    send(code, 16'h0000, 1'b1);
    for (int n = 0; n < 4 && i_rd_valid !== 1'b1; n++) begin
      @(posedge i_clk);
      #1;
    end
    ok = (i_rd_valid === 1'b1);
    d = i_rd_data;
  endtask : read

  // clear-faults pulse
  task automatic clear;
    @(posedge i_clk);
    #1;
    o_clear_faults = 1'b1;
    @(posedge i_clk);
    #1;
    o_clear_faults = 1'b0;
  endtask : clear
endmodule : frrc_host_model

// ---- sim/frrc_assertions.sv ----
// Purpose: port checks for the fault reaction block
// Assumes: one clock, asynchronous active-low reset
// Notes: attached by bind below
`timescale 1ns/1ps

module frrc_assertions #(
  parameter int TICK_CYCLES = 10
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // command port
  input wire frrc_pkg::frrc_cmd_t i_cmd,
  input wire logic i_clear_faults,
  input wire logic o_rd_valid,
  input wire logic o_wr_rejected,
  // fault inputs
  input wire logic i_cold_fault,
  input wire logic i_temp_above_cold_warning,
  input wire logic i_vin_ov_fault,
  input wire logic i_vin_below_ov_caution,
  // outputs
  input wire logic o_output_enable,
  input wire logic o_restart_attempt,
  input wire logic o_alert_line_n,
  input wire logic o_cold_fault_status,
  input wire logic o_vin_ov_fault_status
);
  // ********
  // checks
  // ********
  // any status pin set
  wire any_status = o_cold_fault_status || o_vin_ov_fault_status;

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  // status and alert both show two edges after a cold fault is sampled
  sequence s_cold_flags;
    ##2 (o_cold_fault_status && !o_alert_line_n);
  endsequence

  a_cold_trip_flags: assert property (i_cold_fault |-> s_cold_flags)
    else $error("cold fault flags missing");
  a_vin_status_set: assert property (i_vin_ov_fault |-> ##2 o_vin_ov_fault_status)
    else $error("vin status not set");
  a_status_sticky_hold: assert property (o_cold_fault_status && !$past(i_clear_faults)
    |=> o_cold_fault_status)
    else $error("cold status dropped");
  a_alert_tracks_status: assert property (o_alert_line_n == !any_status)
    else $error("alert wrong");
  a_restart_turns_on: assert property (o_restart_attempt |-> o_output_enable)
    else $error("restart without output");
  a_restart_needs_clear: assert property (o_restart_attempt
    |-> $past(i_temp_above_cold_warning || i_vin_below_ov_caution))
    else $error("restart too early");
  a_restart_spacing_min: assert property (o_restart_attempt |=> !o_restart_attempt [*8])
    else $error("restarts too close");
  a_reject_has_cause: assert property (o_wr_rejected
    |-> $past(i_cmd.wr && i_cmd.code == frrc_pkg::CMD_VIN_OV_TRIP))
    else $error("refusal without write");
  a_read_answer_once: assert property (o_rd_valid == $past(i_cmd.rd))
    else $error("read answer timing");
endmodule : frrc_assertions

bind frrc_fault_ctrl frrc_assertions #(.TICK_CYCLES(TICK_CYCLES)) i_chk (.i_clk(i_clk),
  .i_rst_n(i_rst_n), .i_cmd(i_cmd), .i_clear_faults(i_clear_faults), .o_rd_valid(o_rd_valid),
  .o_wr_rejected(o_wr_rejected), .i_cold_fault(i_cold_fault),
  .i_temp_above_cold_warning(i_temp_above_cold_warning), .i_vin_ov_fault(i_vin_ov_fault),
  .i_vin_below_ov_caution(i_vin_below_ov_caution), .o_output_enable(o_output_enable),
  .o_restart_attempt(o_restart_attempt), .o_alert_line_n(o_alert_line_n),
  .o_cold_fault_status(o_cold_fault_status), .o_vin_ov_fault_status(o_vin_ov_fault_status));

// ---- sim/fault_response_retry_control_bench.sv ----
// Purpose: self-checking bench for the fault reaction block
// Assumes: tick of 10 cycles, strap 90h (response 10, retry 2, delay 0)
// Notes: commands go through the host model
`timescale 1ns/1ps

module fault_response_retry_control_bench;
  localparam int TICKS = 10;
  localparam int MS35 = frrc_pkg::RETRY_UNIT_MS * TICKS;
  logic clk, rst_n, cold, warm, ov, ov_low, en, bias, oth, clr;
  logic rd_valid, rejected, oe, restart, alert_n, cold_st, ov_st;
  logic [15:0] rd_data;
  frrc_pkg::frrc_cmd_t cmd;
  int error_cnt = 0;
  int checks_done = 0;

  // host and block under test
  frrc_host_model i_host (.i_clk(clk), .i_rd_data(rd_data), .i_rd_valid(rd_valid), .o_cmd(cmd),
    .o_clear_faults(clr));
  frrc_fault_ctrl #(.TICK_CYCLES(TICKS)) i_dut (.i_clk(clk), .i_rst_n(rst_n), .i_cmd(cmd),
    .i_clear_faults(clr), .o_rd_data(rd_data), .o_rd_valid(rd_valid), .o_wr_rejected(rejected),
    .i_config_strap_pin_zero(8'h90), .i_cold_fault(cold), .i_temp_above_cold_warning(warm),
    .i_vin_ov_fault(ov), .i_vin_below_ov_caution(ov_low), .i_enable(en), .i_bias_lost(bias),
    .i_other_fault(oth), .o_output_enable(oe), .o_restart_attempt(restart),
    .o_alert_line_n(alert_n), .o_cold_fault_status(cold_st), .o_vin_ov_fault_status(ov_st));

  // ********
  // helpers
  // ********
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_word

  task automatic chk_bit(input string what, input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit

  task automatic finish_test;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic do_reset;
    rst_n = 1'b0;
    cyc(3);
    rst_n = 1'b1;
    cyc(2);
  endtask : do_reset

  task automatic rd_chk(input string what, input logic [7:0] code, input logic [15:0] exp);
    logic [15:0] d;
    logic ok;
    i_host.read(code, d, ok);
    chk_bit("read valid", 1'b1, ok);
    chk_word(what, exp, d);
  endtask : rd_chk

  // bounded wait for a restart pulse
  task automatic wait_restart(input int lim, input bit must, output int n);
    n = 0;
    while (restart !== 1'b1 && n < lim) begin
      cyc(1);
      n++;
    end
    if (must && restart !== 1'b1) begin
      chk_bit("restart", 1'b1, restart);
      finish_test();
    end
  endtask : wait_restart

  // two-cycle fault with the matching warning levels
  task automatic trip(input bit use_ov, input logic exp_oe);
    ov = use_ov;
    cold = !use_ov;
    ov_low = 1'b0;
    warm = 1'b0;
    cyc(1);
    chk_bit("output enable", exp_oe, oe);
    cyc(1);
    chk_bit("fault status", 1'b1, use_ov ? ov_st : cold_st);
    chk_bit("alert low", 1'b0, alert_n);
    ov = 1'b0;
    cold = 1'b0;
  endtask : trip

  task automatic clear_chk;
    i_host.clear();
    cyc(1);
    chk_bit("cold status", 1'b0, cold_st);
    chk_bit("vin status", 1'b0, ov_st);
    chk_bit("alert released", 1'b1, alert_n);
  endtask : clear_chk

  // ********
  // scenarios
  // ********
  task automatic t_trip_level;
    logic [15:0] val [4] = '{16'hd200, 16'h0012, 16'h0013, 16'h07ff};
    logic [15:0] keep;
    keep = 16'hda00;
    for (int k = 0; k < 4; k++) begin
      i_host.send(frrc_pkg::CMD_VIN_OV_TRIP, val[k], 1'b0);
      chk_bit("refused", k > 1, rejected);
      if (k < 2) begin
        keep = val[k];
      end
      rd_chk("trip level", frrc_pkg::CMD_VIN_OV_TRIP, keep);
    end
  endtask : t_trip_level

  task automatic t_cold_retry;
    int n;
    i_host.send(frrc_pkg::CMD_COLD_REACT, 16'h0089, 1'b0);
    trip(1'b0, 1'b0);
    wait_restart(MS35 * 3, 1'b0, n);
    chk_bit("restart while cold", 1'b0, restart);
    warm = 1'b1;
    wait_restart(4, 1'b1, n);
    chk_bit("output on", 1'b1, oe);
    trip(1'b0, 1'b0);
    warm = 1'b1;
    wait_restart(MS35 * 3, 1'b1, n);
    chk_bit("spacing", n + 1 >= MS35 * 2 - 2 && n + 1 <= MS35 * 2 + 4, 1'b1);
    clear_chk();
  endtask : t_cold_retry

  task automatic t_stops;
    int n;
    i_host.send(frrc_pkg::CMD_COLD_REACT, 16'h0080, 1'b0);
    trip(1'b0, 1'b0);
    warm = 1'b1;
    clear_chk();
    wait_restart(MS35 * 2, 1'b0, n);
    chk_bit("latched output", 1'b0, oe);
    // bias loss, then another fault, each stops the retries
    for (int s = 0; s < 2; s++) begin
      do_reset();
      i_host.send(frrc_pkg::CMD_COLD_REACT, 16'h0088, 1'b0);
      trip(1'b0, 1'b0);
      {oth, bias} = (s == 0) ? 2'b01 : 2'b10;
      warm = 1'b1;
      wait_restart(MS35 * 2, 1'b0, n);
      chk_bit("restart after stop", 1'b0, restart);
      {oth, bias} = 2'b00;
    end
    do_reset();
    cyc(1);
    chk_bit("output after reset", 1'b1, oe);
  endtask : t_stops

  task automatic t_vin_retry;
    int n;
    i_host.send(frrc_pkg::CMD_VIN_OV_REACT, 16'h0088, 1'b0);
    trip(1'b1, 1'b0);
    warm = 1'b1;
    wait_restart(MS35 * 2, 1'b0, n);
    chk_bit("restart above caution", 1'b0, restart);
    ov_low = 1'b1;
    wait_restart(4, 1'b1, n);
    chk_bit("output on", 1'b1, oe);
    clear_chk();
  endtask : t_vin_retry

  task automatic t_unused_codes;
    for (int c = 0; c < 4; c++) begin
      if (c != 2) begin
        i_host.send(frrc_pkg::CMD_COLD_REACT, {8'h00, c[1:0], 6'h08}, 1'b0);
        trip(1'b0, 1'b1);
        warm = 1'b1;
        clear_chk();
      end
    end
  endtask : t_unused_codes

  // main sequence
  initial begin
    {cold, warm, ov, ov_low, en, bias, oth} = 7'b0101100;
    do_reset();
    rd_chk("cold config", frrc_pkg::CMD_COLD_REACT, 16'h0090);
    rd_chk("trip level", frrc_pkg::CMD_VIN_OV_TRIP, 16'hda00);
    rd_chk("vin config", frrc_pkg::CMD_VIN_OV_REACT, 16'h0090);
    t_trip_level();
    t_cold_retry();
    t_vin_retry();
    t_unused_codes();
    t_stops();
    finish_test();
  end
endmodule : fault_response_retry_control_bench
